// >>> verilog/wdp_watchdog.sv
// Purpose: pin-configured watchdog supervisor with an AHB-Lite status port
// Assumes: hclk at 250 MHz is the internal oscillator; hresetn stands for power-on
// Notes:   each time is held at its printed minimum; family and output variant are parameters
// How it works
// R1 - code 011 turns the watchdog fully off
// R2 - family A timeouts 1ms, 10ms, 30ms
// R3 - family A timeouts 100ms, 1s, 10s, 60s
// R4 - family B hold is 60s always
// R5 - family B timeout table per code
// R6 - family C hold table per code
// R7 - family C 101/110 hold ends on first edge
// R8 - family C timeout table per code
// R9 - open-drain fault pulse lasts 100ms
// R10 - push-pull fault pulse lasts 1ms
// R11 - kick ignored 100us after reset or reselect
// R12 - processor holds kick level at least 100ns
// R13 - kick edge or fault clears counter; timeout pulses
// R14 - hold restarts on reset or select change
// R15 - no counting, no pulse during hold
// R16 - family A hold equals its timeout
// R17 - family C code 001 hold is 3s
// R18 - select pins form code, bit2 first
module wdp_watchdog
  import wdp_pkg::*;
#(
  parameter wdp_family_t FAMILY     = FAM_A,
  parameter logic        OPEN_DRAIN = 1'b1,
  parameter int unsigned CYC_PER_US = CLK_MHZ,
  parameter int unsigned CNT_W      = 36
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hclk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        kick_input,
  input  wire logic        timing_select_bit0,
  input  wire logic        timing_select_bit1,
  input  wire logic        timing_select_bit2,
  output logic             fault_pulse_n,
  output logic             fault_pulse_oe
);

  typedef struct packed {
    wdp_state_t           state;
    logic [2:0]           sel;
    logic [CNT_W-1:0]     cnt;
    logic                 kick_prev;
    logic                 fault_n;
    logic                 fault_oe;
    logic [FAULT_W-1:0]   faults;
    logic                 wr_pend;
    logic [DEC_W-1:0]     wr_addr;
    logic [31:0]          rdata;
    logic                 ready;
  } wdp_regs_t;

  function automatic logic [CNT_W-1:0] us_to_cyc(input int unsigned us);
    logic [CNT_W-1:0] c;
    c = CNT_W'(us) * CNT_W'(CYC_PER_US);
    if (c == '0)
      c = CNT_W'(1);
    return c;
  endfunction : us_to_cyc

  localparam logic [CNT_W-1:0] SETTLE_CYC = us_to_cyc(TM_SETTLE);
  localparam logic [CNT_W-1:0] PULSE_CYC  = us_to_cyc(OPEN_DRAIN ? TM_PULSE_OD : TM_PULSE_PP);

  localparam wdp_regs_t RST_VAL = '{
    state:     ST_SETTLE,
    sel:       3'h0,
    cnt:       '0,
    kick_prev: 1'b0,
    fault_n:   1'b1,
    fault_oe:  ~OPEN_DRAIN,
    faults:    '0,
    wr_pend:   1'b0,
    wr_addr:   '0,
    rdata:     '0,
    ready:     1'b1
  };

  wdp_regs_t        st;
  wdp_regs_t        n;
  logic [3:0]       pins_s;
  logic             kick_s;
  logic [2:0]       sel_s;
  logic             kick_edge;
  logic             sel_chg;
  logic             first_edge;
  logic             go;
  logic [CNT_W-1:0] to_cyc;
  logic [CNT_W-1:0] hold_cyc;

  // kick and select pins are asynchronous to hclk
  wdp_sync #(
    .W (4)
  ) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hclk_en (hclk_en),
    .d_async ({kick_input, timing_select_bit2, timing_select_bit1, timing_select_bit0}),
    .q       (pins_s)
  );

  assign kick_s     = pins_s[3];
  assign sel_s      = pins_s[2:0];  // see R18
  assign kick_edge  = kick_s ^ st.kick_prev;
  assign sel_chg    = sel_s != st.sel;
  assign go         = hclk_en && !sel_chg;
  assign first_edge = wdp_first_edge(FAMILY, st.sel);  // see R7
  assign to_cyc     = us_to_cyc(wdp_timeout_us(FAMILY, st.sel));  // see R2, see R3, see R5, see R8
  assign hold_cyc   = us_to_cyc(wdp_hold_us(FAMILY, st.sel));  // see R4, see R6, see R16, see R17

  always_comb
  begin
    n           = st;
    n.kick_prev = kick_s;
    n.wr_pend   = 1'b0;
    n.rdata     = '0;
    n.ready     = 1'b1;

    // write data phase: clear first so a fault in the same cycle still counts
    if (st.wr_pend && (st.wr_addr == REG_FAULTS) && hwdata[FLT_CLR_BIT])
      n.faults = '0;

    if (sel_chg)
    begin
      n.sel   = sel_s;  // see R14
      n.state = ST_SETTLE;
      n.cnt   = '0;
    end
    else
    begin
      unique case (st.state)
        ST_SETTLE:
        begin
          // kick edges are not looked at here, so they cannot end a first-edge hold early
          if (st.cnt >= SETTLE_CYC - CNT_W'(1))  // see R11
          begin
            n.cnt   = '0;
            n.state = (st.sel == SEL_OFF) ? ST_OFF : ST_HOLD;  // see R1
          end
          else
            n.cnt = st.cnt + CNT_W'(1);
        end
        ST_HOLD:
        begin
          if (first_edge)
          begin
            if (kick_edge)  // see R7
              n.state = ST_RUN;
          end
          else if (st.cnt >= hold_cyc - CNT_W'(1))  // see R15
          begin
            n.cnt   = '0;
            n.state = ST_RUN;
          end
          else
            n.cnt = st.cnt + CNT_W'(1);
        end
        ST_RUN:
        begin
          if (kick_edge)
            n.cnt = '0;  // see R13
          else if (st.cnt >= to_cyc - CNT_W'(1))
          begin
            n.cnt   = '0;  // see R13
            n.state = ST_FAULT;
            if (n.faults != '1)
              n.faults = n.faults + FAULT_W'(1);
          end
          else
            n.cnt = st.cnt + CNT_W'(1);
        end
        ST_FAULT:
        begin
          // edges during the pulse are not seen; timing restarts when it ends
          if (st.cnt >= PULSE_CYC - CNT_W'(1))  // see R9, see R10
          begin
            n.cnt   = '0;
            n.state = ST_RUN;
          end
          else
            n.cnt = st.cnt + CNT_W'(1);
        end
        ST_OFF:
          n.cnt = '0;
        default:
        begin
          n.state = ST_SETTLE;
          n.cnt   = '0;
        end
      endcase
    end

    n.fault_n  = n.state != ST_FAULT;
    n.fault_oe = OPEN_DRAIN ? (n.state == ST_FAULT) : 1'b1;

    // address phase: read data is captured now so hrdata comes from a flop
    if (hsel && htrans[1] && hready)
    begin
      if (hwrite)
      begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr[DEC_W-1:0];
      end
      else if (haddr[DEC_W-1:0] == REG_STATUS)
      begin
        n.rdata[STS_STATE_LSB +: 3] = st.state;
        n.rdata[STS_SEL_LSB +: 3]   = st.sel;
        n.rdata[STS_FAULTN_BIT]     = st.fault_n;
        n.rdata[STS_FEDGE_BIT]      = first_edge;
        n.rdata[STS_FAM_LSB +: 2]   = FAMILY;
        n.rdata[STS_OD_BIT]         = OPEN_DRAIN;
      end
      else if (haddr[DEC_W-1:0] == REG_FAULTS)
        n.rdata[FAULT_W-1:0] = n.faults;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= RST_VAL;
    else if (hclk_en)
      st <= n;
  end

  assign hreadyout      = st.ready;
  assign hresp          = 1'b0 & st.ready;
  assign hrdata         = st.rdata;
  assign fault_pulse_n  = st.fault_n;
  assign fault_pulse_oe = st.fault_oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  off_quiet_a: assert property ((st.sel == SEL_OFF && st.state != ST_SETTLE) |-> st.state == ST_OFF && st.fault_n) // see R1
    else $error("disabled code left the watchdog active");
  fam_a_short_a: assert property ((FAMILY == FAM_A && st.sel == 3'h1) |-> to_cyc == us_to_cyc(TM_10MS)) // see R2
    else $error("family A code 001 timeout wrong");
  fam_a_long_a: assert property ((FAMILY == FAM_A && st.sel == 3'h7) |-> to_cyc == us_to_cyc(TM_60S)) // see R3
    else $error("family A code 111 timeout wrong");
  fam_b_hold_a: assert property ((FAMILY == FAM_B && st.sel != SEL_OFF) |-> hold_cyc == us_to_cyc(TM_60S)) // see R4
    else $error("family B hold is not fixed");
  fam_b_timeout_a: assert property ((FAMILY == FAM_B && st.sel == 3'h5) |-> to_cyc == us_to_cyc(TM_300MS)) // see R5
    else $error("family B code 101 timeout wrong");
  fam_c_hold_a: assert property ((FAMILY == FAM_C && st.sel == 3'h4) |-> hold_cyc == us_to_cyc(TM_200US)) // see R6
    else $error("family C code 100 hold wrong");
  first_edge_a: assert property ((go && st.state == ST_HOLD && first_edge) |-> ##1 (st.state == ST_RUN) == $past(kick_edge)) // see R7
    else $error("first-edge hold did not follow the kick input");
  fam_c_timeout_a: assert property ((FAMILY == FAM_C && st.sel == 3'h4) |-> to_cyc == us_to_cyc(TM_30US)) // see R8
    else $error("family C code 100 timeout wrong");
  pulse_width_a: assert property ((go && st.state == ST_FAULT && n.state != ST_FAULT) |-> st.cnt == PULSE_CYC - CNT_W'(1)) // see R9, see R10
    else $error("fault pulse length wrong");
  pulse_kind_a: assert property (PULSE_CYC == us_to_cyc(OPEN_DRAIN ? TM_100MS : TM_1MS)) // see R9, see R10
    else $error("fault pulse variant wrong");
  settle_len_a: assert property ((go && st.state == ST_SETTLE && n.state != ST_SETTLE) |-> st.cnt == SETTLE_CYC - CNT_W'(1)) // see R11
    else $error("settle window length wrong");
  kick_clear_a: assert property ((go && st.state == ST_RUN && kick_edge) |=> st.cnt == '0 && st.state == ST_RUN) // see R13
    else $error("kick edge did not clear the timer");
  timeout_fire_a: assert property ((go && st.state == ST_RUN && !kick_edge && st.cnt == to_cyc - CNT_W'(1)) |=> !fault_pulse_n && st.cnt == '0) // see R13
    else $error("timeout did not start a fault pulse");
  reselect_a: assert property ((hclk_en && sel_chg) |=> st.state == ST_SETTLE && st.cnt == '0) // see R14
    else $error("select change did not restart settle");
  // a software clear may land during the hold, so only a count that moves to a non-zero value is an error
  hold_quiet_a: assert property ((st.state == ST_SETTLE || st.state == ST_HOLD) // see R15
    |-> fault_pulse_n && (st.faults == '0 || $stable(st.faults)))
    else $error("fault activity during startup hold");
  fam_a_hold_a: assert property ((FAMILY == FAM_A) |-> hold_cyc == to_cyc) // see R16
    else $error("family A hold differs from timeout");
  fam_c_secs_a: assert property ((FAMILY == FAM_C && st.sel == 3'h1) |-> hold_cyc == us_to_cyc(TM_3S)) // see R17
    else $error("family C code 001 hold wrong");
  // the bus port never stalls and never errors; only the pin side carries the rules
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus port stalled or answered an error");
  oe_follow_a: assert property (fault_pulse_oe == (OPEN_DRAIN ? !fault_pulse_n : 1'b1)) // see R9, see R10
    else $error("output enable does not match the variant");
  fault_count_a: assert property ((go && st.state == ST_RUN && n.state == ST_FAULT) |=> st.faults != '0) // see R13
    else $error("timeout not counted in the fault register");
  off_idle_a: assert property (st.state == ST_OFF |-> st.cnt == '0 && st.sel == SEL_OFF) // see R1
    else $error("disabled watchdog is counting");
  settle_kick_a: assert property ((go && st.state == ST_SETTLE) |=> st.state != ST_RUN) // see R11
    else $error("settle window ended straight into counting");
  hold_end_a: assert property ((go && st.state == ST_HOLD && !first_edge && st.cnt == hold_cyc - CNT_W'(1)) // see R15
    |=> st.state == ST_RUN && st.cnt == '0)
    else $error("timed hold did not hand over to counting");

  fault_seen_c: cover property (st.state == ST_RUN ##1 st.state == ST_FAULT);
  first_edge_c: cover property (st.state == ST_HOLD && first_edge ##1 st.state == ST_RUN);
  off_c:        cover property (st.state == ST_OFF);
  reselect_c:   cover property (st.state == ST_RUN ##1 st.state == ST_SETTLE);
  fault_end_c:  cover property (st.state == ST_FAULT ##1 st.state == ST_RUN);

endmodule : wdp_watchdog

// >>> verilog/wdp_pkg.sv
// Purpose: shared constants, types and timing tables of the pin-select watchdog
// Assumes: all times are held in microseconds; the top module turns them into cycles
// Notes:   select code is {bit2, bit1, bit0}; code 011 disables the watchdog
package wdp_pkg;

  typedef enum logic [1:0]
  {
    FAM_A = 2'h0,
    FAM_B = 2'h1,
    FAM_C = 2'h2
  } wdp_family_t;

  typedef enum logic [2:0]
  {
    ST_SETTLE = 3'h0,
    ST_HOLD   = 3'h1,
    ST_RUN    = 3'h2,
    ST_FAULT  = 3'h3,
    ST_OFF    = 3'h4
  } wdp_state_t;

  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned US_PER_MS  = 1000;
  localparam int unsigned US_PER_S   = 1000000;

  // times, unit microseconds
  localparam int unsigned TM_30US    = 30;
  localparam int unsigned TM_100US   = 100;
  localparam int unsigned TM_200US   = 200;
  localparam int unsigned TM_1MS     = 1 * US_PER_MS;
  localparam int unsigned TM_3MS     = 3 * US_PER_MS;
  localparam int unsigned TM_10MS    = 10 * US_PER_MS;
  localparam int unsigned TM_30MS    = 30 * US_PER_MS;
  localparam int unsigned TM_100MS   = 100 * US_PER_MS;
  localparam int unsigned TM_300MS   = 300 * US_PER_MS;
  localparam int unsigned TM_1S      = 1 * US_PER_S;
  localparam int unsigned TM_3S      = 3 * US_PER_S;
  localparam int unsigned TM_10S     = 10 * US_PER_S;
  localparam int unsigned TM_60S     = 60 * US_PER_S;

  localparam int unsigned TM_SETTLE  = TM_100US;
  localparam int unsigned TM_PULSE_OD = TM_100MS;
  localparam int unsigned TM_PULSE_PP = TM_1MS;

  localparam logic [2:0] SEL_OFF     = 3'h3;

  // register map, byte addresses
  localparam int unsigned DEC_W      = 8;
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_FAULTS  = 8'h04;
  localparam int unsigned FAULT_W    = 16;
  localparam int unsigned FLT_CLR_BIT = 0;

  // status fields
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_SEL_LSB   = 4;
  localparam int unsigned STS_FAULTN_BIT = 8;
  localparam int unsigned STS_FEDGE_BIT = 9;
  localparam int unsigned STS_FAM_LSB   = 12;
  localparam int unsigned STS_OD_BIT    = 14;

  function automatic int unsigned wdp_timeout_us(input wdp_family_t fam, input logic [2:0] sel);
    int unsigned t;
    t = 0;
    case ({fam, sel})
      {FAM_A, 3'h0}: t = TM_1MS;
      {FAM_A, 3'h1}: t = TM_10MS;
      {FAM_A, 3'h2}: t = TM_30MS;
      {FAM_A, 3'h4}: t = TM_100MS;
      {FAM_A, 3'h5}: t = TM_1S;
      {FAM_A, 3'h6}: t = TM_10S;
      {FAM_A, 3'h7}: t = TM_60S;
      {FAM_B, 3'h0}: t = TM_1MS;
      {FAM_B, 3'h1}: t = TM_3MS;
      {FAM_B, 3'h2}: t = TM_10MS;
      {FAM_B, 3'h4}: t = TM_100MS;
      {FAM_B, 3'h5}: t = TM_300MS;
      {FAM_B, 3'h6}: t = TM_3S;
      {FAM_B, 3'h7}: t = TM_60S;
      {FAM_C, 3'h0}: t = TM_3MS;
      {FAM_C, 3'h1}: t = TM_3S;
      {FAM_C, 3'h2}: t = TM_1S;
      {FAM_C, 3'h4}: t = TM_30US;
      {FAM_C, 3'h5}: t = TM_1S;
      {FAM_C, 3'h6}: t = TM_10S;
      {FAM_C, 3'h7}: t = TM_10S;
      default:       t = 0;
    endcase
    return t;
  endfunction : wdp_timeout_us

  function automatic int unsigned wdp_hold_us(input wdp_family_t fam, input logic [2:0] sel);
    int unsigned t;
    t = 0;
    if (sel != SEL_OFF)
    begin
      case (fam)
        FAM_A:   t = wdp_timeout_us(fam, sel);
        FAM_B:   t = TM_60S;
        default:
        begin
          case (sel)
            3'h0:    t = TM_3MS;
            3'h1:    t = TM_3S;
            3'h2:    t = TM_60S;
            3'h4:    t = TM_200US;
            3'h7:    t = TM_60S;
            default: t = 0;
          endcase
        end
      endcase
    end
    return t;
  endfunction : wdp_hold_us

  function automatic logic wdp_first_edge(input wdp_family_t fam, input logic [2:0] sel);
    return (fam == FAM_C) && ((sel == 3'h5) || (sel == 3'h6));
  endfunction : wdp_first_edge

endpackage : wdp_pkg

// >>> verilog/wdp_sync.sv
// Purpose: two-stage synchroniser for the asynchronous watchdog pins
// Assumes: one clock; the enable freezes both stages
// Notes:   only the second stage is visible outside
module wdp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hclk_en,
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (hclk_en)
    begin
      meta_ff <= d_async;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule : wdp_sync

// >>> dv/wdp_cpu_model.sv
// Purpose: supervised processor that toggles the kick pin at a set pace
// Assumes: level pin with no release state; the pin keeps its level between kicks
// Notes:   pace is given in clock cycles per level
module wdp_cpu_model
(
  input  wire logic        hclk,
  input  wire logic        kick_en,
  input  wire logic [15:0] half_cycles,
  output logic             kick_input
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] cnt_ff;
  logic [15:0] span;

  // never shorter than 25 cycles, so each level is held at least 100 ns at 250 MHz
  assign span = (half_cycles < 16'h19) ? 16'h19 : half_cycles;

  initial
  begin
    kick_input = 1'b0;
    cnt_ff     = 16'h0;
  end

  always @(posedge hclk)
  begin
    if (!kick_en)
      cnt_ff <= 16'h0;
    else if (cnt_ff + 16'h1 >= span)
    begin
      cnt_ff     <= 16'h0;
      kick_input <= ~kick_input;
    end
    else
      cnt_ff <= cnt_ff + 16'h1;
  end
endmodule : wdp_cpu_model

// >>> dv/wdp_watchdog_tb.sv
// Purpose: self-checking bench of the pin-select watchdog, family A, push-pull
// Assumes: CYC_PER_US = 1, so every time in microseconds is that many cycles
// Notes:   long codes are left out to keep the run short
module wdp_watchdog_tb;
  import wdp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned TRIP = TM_SETTLE + 2 * TM_1MS;

  logic        hclk;
  logic        hresetn;
  logic        hclk_en;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        kick_en;
  logic [15:0] half_cycles;
  logic        kick_input;
  logic [2:0]  pins;
  logic        fault_pulse_n;
  logic        fault_pulse_oe;
  int          cyc;
  int          rel_cyc;
  int          mismatches;
  int          comparisons;

  assign hready = hreadyout;

  wdp_watchdog #(.FAMILY(FAM_A), .OPEN_DRAIN(1'b0), .CYC_PER_US(1), .CNT_W(36)) i_wdp_watchdog
  (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hclk_en            (hclk_en),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (3'h2),
    .hwdata             (hwdata),
    .hready             (hready),
    .hreadyout          (hreadyout),
    .hresp              (hresp),
    .hrdata             (hrdata),
    .kick_input         (kick_input),
    .timing_select_bit0 (pins[0]),
    .timing_select_bit1 (pins[1]),
    .timing_select_bit2 (pins[2]),
    .fault_pulse_n      (fault_pulse_n),
    .fault_pulse_oe     (fault_pulse_oe)
  );

  wdp_cpu_model i_wdp_cpu_model
  (
    .hclk        (hclk),
    .kick_en     (kick_en),
    .half_cycles (half_cycles),
    .kick_input  (kick_input)
  );

  initial
  begin
    hclk = 1'b0;
    cyc  = 0;
  end
  always #2 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
    end
  endtask : chk

  // single word transfer; the answer is taken at the edge where hready is high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp, what);
  endtask : rd_chk

  task automatic wait_fault(input int lim, output int n);
    n = 0;
    while (fault_pulse_n !== 1'b0 && n < lim)
    begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_fault

  task automatic no_fault(input int cycles, input string what);
    logic bad;
    bad = 1'b0;
    repeat (cycles)
    begin
      @(posedge hclk);
      if (fault_pulse_n !== 1'b1)
        bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0, what);
  endtask : no_fault

  task automatic t_reset_status();
    logic [31:0] d;
    repeat (20) @(posedge hclk);
    rd_chk({24'h0, REG_STATUS}, 32'h0000_0100, "status after reset");
    rd_chk({24'h0, REG_FAULTS}, 32'h0, "fault count after reset");
    bus(1'b1, 32'h08, 32'hFFFF_FFFF, d);
    rd_chk(32'h08, 32'h0, "unmapped read");
    $display("test reset_status done");
  endtask : t_reset_status

  task automatic t_first_timeout();
    int n;
    int el;
    logic oe_bad;
    wait_fault(5000, n);
    el = cyc - rel_cyc;
    chk({31'h0, (el >= TRIP) && (el <= TRIP + 10)}, 32'h1, "first trip time");
    n      = 0;
    oe_bad = 1'b0;
    while (fault_pulse_n === 1'b0 && n < 5000)
    begin
      if (fault_pulse_oe !== 1'b1)
        oe_bad = 1'b1;
      @(posedge hclk);
      n++;
    end
    chk(n, TM_PULSE_PP, "pulse length");
    chk({31'h0, oe_bad}, 32'h0, "push-pull enable");
    $display("test first_timeout done");
  endtask : t_first_timeout

  task automatic t_kicks_alive();
    logic [31:0] d;
    half_cycles <= 16'hC8;
    kick_en     <= 1'b1;
    no_fault(5000, "kicked watchdog stays quiet");
    rd_chk({24'h0, REG_FAULTS}, 32'h1, "one fault counted");
    bus(1'b1, {24'h0, REG_FAULTS}, 32'h1, d);
    rd_chk({24'h0, REG_FAULTS}, 32'h0, "fault count cleared");
    kick_en <= 1'b0;
    $display("test kicks_alive done");
  endtask : t_kicks_alive

  task automatic t_disable();
    pins <= SEL_OFF;
    repeat (10) @(posedge hclk);
    no_fault(3000, "disabled watchdog quiet");
    rd_chk({24'h0, REG_STATUS}, 32'h0000_0134, "status when off");
    $display("test disable done");
  endtask : t_disable

  task automatic t_reselect();
    int st;
    int n;
    pins <= 3'h0;
    @(posedge hclk);
    st = cyc;
    // the new code needs two sync stages and one state edge before status can show it
    repeat (4) @(posedge hclk);
    rd_chk({24'h0, REG_STATUS}, 32'h0000_0100, "settle after reselect");
    while (cyc - st < 600) @(posedge hclk);
    rd_chk({24'h0, REG_STATUS}, 32'h0000_0101, "hold after settle");
    // freezing the hold for 500 cycles must push the trip back by exactly that much
    hclk_en <= 1'b0;
    repeat (500) @(posedge hclk);
    hclk_en <= 1'b1;
    wait_fault(5000, n);
    chk({31'h0, (cyc - st >= TRIP + 500) && (cyc - st <= TRIP + 510)}, 32'h1, "trip after reselect");
    while (fault_pulse_n === 1'b0) @(posedge hclk);
    $display("test reselect done");
  endtask : t_reselect

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    mismatches  = 0;
    comparisons = 0;
    hresetn     = 1'b0;
    hclk_en     = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    kick_en     = 1'b0;
    half_cycles = 16'hC8;
    pins        = 3'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rel_cyc = cyc;
    t_reset_status();
    t_first_timeout();
    t_kicks_alive();
    t_disable();
    t_reselect();
    end_of_test();
  end

  // the tests need about 15000 cycles; four times that means a hang
  initial
  begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    end_of_test();
  end
endmodule : wdp_watchdog_tb
